// ==== src/qppc_pin_cell.sv ====
/*
  One port of pins: input synchroniser with agreement filter, and the registered
  per-pin driver that turns drive code and data bit into out, enable and pull-up.
  Assumes pin inputs are asynchronous and the pad resolves the level from the enables.
*/
`timescale 1ns/1ps
module qppc_pin_cell
  import qppc_pkg::*;
#(
  parameter int WIDTH = PORT_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pinIn,
  input wire logic [WIDTH-1:0] dataBits,
  input wire logic [WIDTH-1:0] selLo,
  input wire logic [WIDTH-1:0] selHi,
  output logic [WIDTH-1:0] pinOut,
  output logic [WIDTH-1:0] pinOe_n,
  output logic [WIDTH-1:0] pinPullUp,
  output logic [WIDTH-1:0] pinLevel
);

  typedef struct packed {
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] sync3;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] out;
    logic [WIDTH-1:0] oeN;
    logic [WIDTH-1:0] pull;
  } qppc_cell_t;

  qppc_cell_t s_q;
  qppc_cell_t s_d;

  // The first stage is read only by the second, so a metastable sample never reaches logic.
  always_comb
  begin
    logic [2:0] drv;
    drv = 3'h2;
    s_d = s_q;
    s_d.sync1 = pinIn;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s_q.sync2[i] == s_q.sync3[i])
      begin
        s_d.level[i] = s_q.sync3[i];
      end
      drv = qppc_drive({selHi[i], selLo[i]}, dataBits[i]);
      s_d.out[i] = drv[2];
      s_d.oeN[i] = drv[1];
      s_d.pull[i] = drv[0];
    end
  end

  // Reset leaves every driver off until the configuration has been applied once.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.sync1 <= '0;
      s_q.sync2 <= '0;
      s_q.sync3 <= '0;
      s_q.level <= '0;
      s_q.out <= '0;
      s_q.oeN <= '1;
      s_q.pull <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pinOut = s_q.out;
  assign pinOe_n = s_q.oeN;
  assign pinPullUp = s_q.pull;
  assign pinLevel = s_q.level;

endmodule : qppc_pin_cell

// ==== src/qppc_pkg.sv ====
/*
  Shared constants, types and helpers for the four-port pin configuration block.
  Assumes a 32-bit AHB-Lite register bus and a single 100 MHz system clock.
*/
package qppc_pkg;

  // Port geometry.
  localparam int NUM_PORTS = 4;
  localparam int PORT_W = 8;
  localparam int BUS_W = 32;

  // Register groups: byte address bits [5:4] select the group, [3:2] the port.
  localparam logic [1:0] GRP_PIN_DATA = 2'h0;
  localparam logic [1:0] GRP_SEL_LO = 2'h1;
  localparam logic [1:0] GRP_SEL_HI = 2'h2;
  localparam logic [1:0] GRP_PIN_LEVEL = 2'h3;
  localparam int GRP_LSB = 4;
  localparam int PORT_LSB = 2;
  localparam int MAP_TOP = 6;

  // Byte addresses of the registers, one aligned word each.
  localparam logic [7:0] OFS_PORT0_PIN_DATA = 8'h00;
  localparam logic [7:0] OFS_PORT3_PIN_DATA = 8'h0C;
  localparam logic [7:0] OFS_PORT0_DRIVE_SEL_LO = 8'h10;
  localparam logic [7:0] OFS_PORT0_DRIVE_SEL_HI = 8'h20;
  localparam logic [7:0] OFS_PORT0_PIN_LEVEL = 8'h30;

  // Reset values: every pin starts quasi-bidirectional with its latch high.
  localparam logic [7:0] PIN_DATA_RESET = 8'hFF;
  localparam logic [7:0] SEL_LO_RESET = 8'hFF;
  localparam logic [7:0] SEL_HI_RESET = 8'h00;

  // Two-bit drive codes, upper bit from the high select register.
  localparam logic [1:0] DRV_OPEN_DRAIN = 2'h0;
  localparam logic [1:0] DRV_QUASI = 2'h1;
  localparam logic [1:0] DRV_HIGH_Z = 2'h2;
  localparam logic [1:0] DRV_PUSH_PULL = 2'h3;

  // AHB-Lite encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Result of decoding a bus address.
  typedef struct packed {
    logic valid;
    logic writable;
    logic [1:0] group;
    logic [1:0] port;
  } qppc_decode_t;

  // Register-file state of the top module.
  typedef struct packed {
    logic [BUS_W-1:0] rdata;
    logic ready;
    logic resp;
    logic wrPend;
    logic [1:0] wrGroup;
    logic [1:0] wrPort;
    logic [NUM_PORTS-1:0][PORT_W-1:0] data;
    logic [NUM_PORTS-1:0][PORT_W-1:0] selLo;
    logic [NUM_PORTS-1:0][PORT_W-1:0] selHi;
  } qppc_regs_t;

  // Splits a byte address into group and port; misaligned or high addresses are unmapped.
  function automatic qppc_decode_t qppc_decode(input logic [BUS_W-1:0] addr);
    qppc_decode_t r;
    r.group = addr[GRP_LSB+1:GRP_LSB];
    r.port = addr[PORT_LSB+1:PORT_LSB];
    r.valid = (addr[BUS_W-1:MAP_TOP] == '0) && (addr[PORT_LSB-1:0] == '0);
    r.writable = r.valid && (r.group != GRP_PIN_LEVEL);
    return r;
  endfunction : qppc_decode

  // Returns {out, oe_n, pullUp} for one pin from its code and data bit.
  function automatic logic [2:0] qppc_drive(input logic [1:0] code, input logic data);
    logic [2:0] r;
    r = 3'h2;
    unique case (code)
      DRV_OPEN_DRAIN: r = {1'b0, data, 1'b0};
      DRV_QUASI: r = {1'b0, data, data};
      DRV_HIGH_Z: r = 3'h2;
      DRV_PUSH_PULL: r = {data, 1'b0, 1'b0};
    endcase
    return r;
  endfunction : qppc_drive

endpackage : qppc_pkg

// ==== src/qppc_top.sv ====
/*
  Four 8-bit general-purpose ports with per-pin drive selection, reached as an
  AHB-Lite slave. Holds the register file and one pin cell per port.
  Assumes it is the only slave on its bus segment, so hready mirrors hreadyout,
  and that the pad ring resolves each pin from out, output enable and pull-up.
*/
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps

// Summary of operation
// - Each of the four ports owns an eight-bit data register whose bits map one to one onto its pins.
// - Pin x takes its two-bit drive code from bit x of the port's high and low select registers, high bit as the upper code bit.
// - Code 00 makes the pin open-drain, able only to pull the line low.
// - Code 01 makes the pin quasi-bidirectional.
// - Code 10 turns the driver off so the pin is a high-impedance input.
// - Code 11 drives the pin push-pull, high and low, following the data bit.
module qppc_top
  import qppc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [BUS_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [BUS_W-1:0] hrdata,
  input wire logic [PORT_W-1:0] port0PinIn,
  output logic [PORT_W-1:0] port0PinOut,
  output logic [PORT_W-1:0] port0PinOe_n,
  output logic [PORT_W-1:0] port0PinPullUp,
  input wire logic [PORT_W-1:0] port1PinIn,
  output logic [PORT_W-1:0] port1PinOut,
  output logic [PORT_W-1:0] port1PinOe_n,
  output logic [PORT_W-1:0] port1PinPullUp,
  input wire logic [PORT_W-1:0] port2PinIn,
  output logic [PORT_W-1:0] port2PinOut,
  output logic [PORT_W-1:0] port2PinOe_n,
  output logic [PORT_W-1:0] port2PinPullUp,
  input wire logic [PORT_W-1:0] port3PinIn,
  output logic [PORT_W-1:0] port3PinOut,
  output logic [PORT_W-1:0] port3PinOe_n,
  output logic [PORT_W-1:0] port3PinPullUp
);

  // Register file and bus-phase state, all in one record.
  qppc_regs_t r_q;
  qppc_regs_t r_d;

  // Per-port views of the pins, indexed by port number for the generate loop.
  logic [NUM_PORTS-1:0][PORT_W-1:0] pinInAll;
  logic [NUM_PORTS-1:0][PORT_W-1:0] pinOutAll;
  logic [NUM_PORTS-1:0][PORT_W-1:0] pinOeAll_n;
  logic [NUM_PORTS-1:0][PORT_W-1:0] pinPullAll;
  logic [NUM_PORTS-1:0][PORT_W-1:0] pinLevelAll;

  // Address phase decode, widened to the bus word so the package helper fits any ADDR_W.
  logic [BUS_W-1:0] addrWide;
  qppc_decode_t dec;
  logic addrPhase;

  assign addrWide = BUS_W'(haddr);
  assign dec = qppc_decode(addrWide);

  // Only NONSEQ and SEQ start a transfer; IDLE and BUSY are answered with nothing.
  assign addrPhase = hsel && hready && htrans[1];

  // Gather the separate port pins into arrays.
  assign pinInAll[0] = port0PinIn;
  assign pinInAll[1] = port1PinIn;
  assign pinInAll[2] = port2PinIn;
  assign pinInAll[3] = port3PinIn;

  // Each port gets its own pin cell; the cell registers every pad control signal.
  generate
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : gPort
      qppc_pin_cell #(
        .WIDTH(PORT_W)
      ) uCell (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(pinInAll[p]),
        .dataBits(r_q.data[p]),
        .selLo(r_q.selLo[p]),
        .selHi(r_q.selHi[p]),
        .pinOut(pinOutAll[p]),
        .pinOe_n(pinOeAll_n[p]),
        .pinPullUp(pinPullAll[p]),
        .pinLevel(pinLevelAll[p])
      );
    end
  endgenerate

  // Spread the arrays back onto the port pins.
  assign port0PinOut = pinOutAll[0];
  assign port0PinOe_n = pinOeAll_n[0];
  assign port0PinPullUp = pinPullAll[0];
  assign port1PinOut = pinOutAll[1];
  assign port1PinOe_n = pinOeAll_n[1];
  assign port1PinPullUp = pinPullAll[1];
  assign port2PinOut = pinOutAll[2];
  assign port2PinOe_n = pinOeAll_n[2];
  assign port2PinPullUp = pinPullAll[2];
  assign port3PinOut = pinOutAll[3];
  assign port3PinOe_n = pinOeAll_n[3];
  assign port3PinPullUp = pinPullAll[3];

  // Bus slave and register file.
  // A write lands at the end of its data phase, which is the same edge that takes
  // the next address phase. The read mux looks at the updated copy, so a read
  // that follows a write to the same register sees the new value with no wait state.
  always_comb
  begin
    logic [PORT_W-1:0] rd;
    rd = '0;
    r_d = r_q;

    // The slave never stretches a transfer and never reports an error.
    r_d.ready = 1'b1;
    r_d.resp = HRESP_OKAY;

    // Data phase of a pending write: only the low byte is stored.
    if (r_q.wrPend && hready)
    begin
      unique case (r_q.wrGroup)
        GRP_PIN_DATA: r_d.data[r_q.wrPort] = hwdata[PORT_W-1:0];
        GRP_SEL_LO: r_d.selLo[r_q.wrPort] = hwdata[PORT_W-1:0];
        GRP_SEL_HI: r_d.selHi[r_q.wrPort] = hwdata[PORT_W-1:0];
        GRP_PIN_LEVEL: r_d.data[r_q.wrPort] = r_q.data[r_q.wrPort];
      endcase
      r_d.wrPend = 1'b0;
    end

    // Address phase: remember a write, or prepare the read word right away.
    if (addrPhase)
    begin
      r_d.wrPend = hwrite && dec.writable;
      r_d.wrGroup = dec.group;
      r_d.wrPort = dec.port;
      if (!hwrite)
      begin
        if (dec.valid)
        begin
          unique case (dec.group)
            GRP_PIN_DATA: rd = r_d.data[dec.port];
            GRP_SEL_LO: rd = r_d.selLo[dec.port];
            GRP_SEL_HI: rd = r_d.selHi[dec.port];
            GRP_PIN_LEVEL: rd = pinLevelAll[dec.port];
          endcase
        end
        // Unmapped reads return zero; the upper bits always read zero.
        r_d.rdata = BUS_W'(rd);
      end
    end
  end

  // Reset values put every port into weak-high quasi mode, the safest state for unknown loads.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q.rdata <= '0;
      r_q.ready <= 1'b1;
      r_q.resp <= HRESP_OKAY;
      r_q.wrPend <= 1'b0;
      r_q.wrGroup <= GRP_PIN_DATA;
      r_q.wrPort <= '0;
      r_q.data <= {NUM_PORTS{PIN_DATA_RESET}};
      r_q.selLo <= {NUM_PORTS{SEL_LO_RESET}};
      r_q.selHi <= {NUM_PORTS{SEL_HI_RESET}};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // Bus outputs come straight from the state record.
  assign hreadyout = r_q.ready;
  assign hresp = r_q.resp;
  assign hrdata = r_q.rdata;

endmodule : qppc_top

// ==== verif/qppc_chk.sv ====
/*
  Port-level assertions for qppc_top, bound into it.
  Assumes hready is tied to hreadyout on a one-slave bus.
*/
`timescale 1ns/1ps
module qppc_chk
  import qppc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [BUS_W-1:0] hrdata,
  input wire logic [PORT_W-1:0] port0PinOut,
  input wire logic [PORT_W-1:0] port0PinOe_n,
  input wire logic [PORT_W-1:0] port0PinPullUp,
  input wire logic [PORT_W-1:0] port1PinOut,
  input wire logic [PORT_W-1:0] port1PinOe_n,
  input wire logic [PORT_W-1:0] port1PinPullUp,
  input wire logic [PORT_W-1:0] port2PinOut,
  input wire logic [PORT_W-1:0] port2PinOe_n,
  input wire logic [PORT_W-1:0] port2PinPullUp,
  input wire logic [PORT_W-1:0] port3PinOut,
  input wire logic [PORT_W-1:0] port3PinOe_n,
  input wire logic [PORT_W-1:0] port3PinPullUp
);
  logic take;
  logic [31:0] po;
  logic [31:0] oe;
  logic [31:0] pu;
  logic [1:0] live_q;
  // All four ports viewed as one vector each.
  assign take = hsel && hready && htrans[1];
  assign po = {port3PinOut, port2PinOut, port1PinOut, port0PinOut};
  assign oe = {port3PinOe_n, port2PinOe_n, port1PinOe_n, port0PinOe_n};
  assign pu = {port3PinPullUp, port2PinPullUp, port1PinPullUp, port0PinPullUp};
  // The pins load once after reset; skip that change.
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      live_q <= 2'h0;
    else
      live_q <= {live_q[0], 1'b1};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pull_undriven: assert property ((pu & ~oe) == '0)
    else $error("pull-up while driving");
  a_high_driven: assert property ((po & oe) == '0)
    else $error("high level while not driving");
  a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus not ready or not okay");
  a_byte_wide: assert property (hrdata[BUS_W-1:PORT_W] == '0)
    else $error("read data above bit 7");
  a_read_holds: assert property (!$past(take && !hwrite) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (take && !hwrite && haddr[ADDR_W-1:MAP_TOP] != '0
    |=> hrdata == '0) else $error("unmapped read not zero");
  a_pin_cause: assert property (live_q[1] && $changed({po, oe, pu})
    |-> $past(take && hwrite, 3)) else $error("pins moved without a write");
  c_write: cover property (take && hwrite);
  c_read: cover property (take && !hwrite);
  c_push_high: cover property (po != '0);
endmodule : qppc_chk

bind qppc_top qppc_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .port0PinOut(port0PinOut), .port0PinOe_n(port0PinOe_n),
  .port0PinPullUp(port0PinPullUp), .port1PinOut(port1PinOut), .port1PinOe_n(port1PinOe_n),
  .port1PinPullUp(port1PinPullUp), .port2PinOut(port2PinOut), .port2PinOe_n(port2PinOe_n),
  .port2PinPullUp(port2PinPullUp), .port3PinOut(port3PinOut), .port3PinOe_n(port3PinOe_n),
  .port3PinPullUp(port3PinPullUp));

// ==== verif/tb_qppc_top.sv ====
/*
  Bench for qppc_top: AHB-Lite register tasks, drive codes, pin levels, refusals.
  Assumes a zero-wait slave whose hreadyout feeds hready.
*/
`timescale 1ns/1ps
module tb_qppc_top
  import qppc_pkg::*;
();
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] haddr = 8'h00;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [7:0] pIn [4];
  logic [7:0] pOut [4];
  logic [7:0] pOe [4];
  logic [7:0] pPu [4];
  logic [7:0] d;
  int n_mismatch = 0;
  int compares = 0;
  // Free-running clock; the slave's ready closes the bus loop.
  initial forever #5 clk = ~clk;
  assign hready = hreadyout;
  qppc_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .port0PinIn(pIn[0]), .port0PinOut(pOut[0]),
    .port0PinOe_n(pOe[0]), .port0PinPullUp(pPu[0]), .port1PinIn(pIn[1]),
    .port1PinOut(pOut[1]), .port1PinOe_n(pOe[1]), .port1PinPullUp(pPu[1]),
    .port2PinIn(pIn[2]), .port2PinOut(pOut[2]), .port2PinOe_n(pOe[2]),
    .port2PinPullUp(pPu[2]), .port3PinIn(pIn[3]), .port3PinOut(pOut[3]),
    .port3PinOe_n(pOe[3]), .port3PinPullUp(pPu[3]));
  task automatic give_verdict(input bit hung);
    if (hung)
      n_mismatch++;
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Bounded wait for hready at a rising edge.
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      @(posedge clk);
      k++;
      if (k > 50)
        give_verdict(1'b1);
    end
  endtask : wait_rdy
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata;
    chk("bus resp", 8'(HRESP_OKAY), 8'(hresp));
  endtask : bus
  function automatic logic [7:0] ad(input logic [1:0] g, input int p);
    return {2'h0, g, 2'(p), 2'h0};
  endfunction : ad
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk($sformatf("reg %h", a), e, rd[7:0]);
  endtask : rdc
  // Expected {out, oe_n, pull} per pin, worked out from the code table.
  task automatic pins(input int p, input logic [7:0] hi, input logic [7:0] lo);
    logic [7:0] eo;
    logic [7:0] ee;
    logic [7:0] ep;
    for (int i = 0; i < 8; i++)
      case ({hi[i], lo[i]})
        2'h0: {eo[i], ee[i], ep[i]} = {1'b0, d[i], 1'b0};
        2'h1: {eo[i], ee[i], ep[i]} = {1'b0, d[i], d[i]};
        2'h2: {eo[i], ee[i], ep[i]} = 3'h2;
        default: {eo[i], ee[i], ep[i]} = {d[i], 2'h0};
      endcase
    chk("pin out", eo, pOut[p]);
    chk("pin oe_n", ee, pOe[p]);
    chk("pin pull", ep, pPu[p]);
  endtask : pins
  // Main sequence: reset, drive codes, pin levels, refusals.
  initial
  begin
    foreach (pIn[i]) pIn[i] <= 8'h00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    d = PIN_DATA_RESET;
    for (int p = 0; p < 4; p++)
    begin
      rdc(ad(GRP_PIN_DATA, p), PIN_DATA_RESET);
      rdc(ad(GRP_SEL_LO, p), SEL_LO_RESET);
      rdc(ad(GRP_SEL_HI, p), SEL_HI_RESET);
      pins(p, SEL_HI_RESET, SEL_LO_RESET);
    end
    $display("Test reset done");
    for (int p = 0; p < 4; p++)
    begin
      bus(ad(GRP_PIN_DATA, p), 1'b1, 8'hA5 ^ {4{2'(p)}});
      bus(ad(GRP_SEL_LO, p), 1'b1, 8'hCC);
      bus(ad(GRP_SEL_HI, p), 1'b1, 8'hF0);
    end
    repeat (2) @(posedge clk);
    #1;
    for (int p = 0; p < 4; p++)
    begin
      d = 8'hA5 ^ {4{2'(p)}};
      pins(p, 8'hF0, 8'hCC);
      rdc(ad(GRP_PIN_DATA, p), d);
    end
    $display("Test drive codes done");
    for (int p = 0; p < 4; p++)
      pIn[p] <= 8'h3C ^ 8'(p);
    repeat (6) @(posedge clk);
    for (int p = 0; p < 4; p++)
      rdc(ad(GRP_PIN_LEVEL, p), 8'h3C ^ 8'(p));
    bus(ad(GRP_PIN_LEVEL, 0), 1'b1, 8'h00);
    rdc(ad(GRP_PIN_LEVEL, 0), 8'h3C);
    bus(8'h40, 1'b1, 8'h00);
    rdc(8'h40, 8'h00);
    rdc(ad(GRP_PIN_DATA, 0), 8'hA5);
    $display("Test levels and refusals done");
    // A reset in mid-run must bring back the quasi, weak-high state, checked here on the pins of port 0.
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    d = PIN_DATA_RESET;
    rdc(ad(GRP_PIN_DATA, 0), PIN_DATA_RESET);
    rdc(ad(GRP_SEL_LO, 0), SEL_LO_RESET);
    rdc(ad(GRP_SEL_HI, 0), SEL_HI_RESET);
    pins(0, SEL_HI_RESET, SEL_LO_RESET);
    $display("Test mid-run reset done");
    give_verdict(1'b0);
  end
endmodule : tb_qppc_top
